// ===== hw/bs_config_regs.sv
// Battery sense configuration registers with impedance sequencer and supervisor logic.
// How it works
// - Each timing code: 00 skips sample, 01/10/11 wait 10/100/1000 ms.
// - Open-cell skipped means loaded sample taken with switch kept closed.
// - Writing active bit starts a measurement; ignored while one runs.
// - Active bit reads 1 throughout, clears when sequence completes.
// - Abort write stops measurement at once; readback 0 means aborted.
// - Three-bit test current code drives load; 111 reserved.
// - Sense mux runs only when enabled; off state pulldown or float.
// - Boot delay code selects 80, 120, 220 or 420 ms.
// - Soft reset restores defaults only when defaults bit is set.
// - Pull configuration bit enables key input pin pulls.
// - Pin status shows live levels of four control pins.
// - Discharge bits add discharge when converter enable field is 00.
// - Start-off strap keeps device off instead of powering up.
// - Global passive discharge enables passive loads in off mode.
// - Host must set keepalive within 5 s or device shuts down.
// - Once keepalive is set, further writes change nothing.
// - LDO lockout select: 0 LDO input, 1 buck-boost input.
// - Read-only converter lockout select picks supply for both converters.
`timescale 1ns/100ps
`include "bs_consts.svh"

module bs_config_regs #(
	parameter int CYC_PER_MS = `BS_CYC_PER_MS
) (
	input  wire logic               i_ref_clk,
	input  wire logic               i_rstn,
	input  wire bs_pkg::bs_bus_s    i_bus,
	output logic [7:0]              o_reg_rdata,
	output logic                    o_addr_valid,
	input  wire bs_pkg::bs_strap_s  i_strap,
	input  wire logic               i_soft_rst,
	input  wire logic [3:0]         i_pins,
	input  wire logic [7:0]         i_adc_code,
	input  wire logic               i_adc_error,
	output logic                    o_adc_sample,
	output logic                    o_switch_open,
	output logic [2:0]              o_test_current,
	output logic                    o_sense_enable,
	output logic [2:0]              o_sense_select,
	output logic                    o_sense_pulldown,
	output logic                    o_key_pull_en,
	output logic                    o_boot_done,
	output logic                    o_power_seq_go,
	input  wire logic [1:0]         i_boost_enable_field,
	input  wire logic [1:0]         i_buck_enable_field,
	input  wire logic               i_enter_off,
	input  wire logic               i_off_mode,
	output logic [3:0]              o_discharge,
	output logic                    o_passive_loads_en,
	output logic                    o_shutdown,
	output logic                    o_ldo_lockout_sel,
	output logic                    o_conv_lockout_sel
);
	localparam int PW = $clog2(CYC_PER_MS + 1);

	// ======================================================================
	// Helpers
	function automatic logic [9:0] delay_ms(input logic [1:0] code);
		case (code)
			2'b01:   delay_ms = `BS_T_SHORT_MS;
			2'b10:   delay_ms = `BS_T_MID_MS;
			2'b11:   delay_ms = `BS_T_LONG_MS;
			default: delay_ms = 10'd0;
		endcase
	endfunction

	function automatic logic [1:0] step_code(input bs_pkg::bs_meas_e st, input logic [5:0] tm, input logic skip2);
		case (st)
			bs_pkg::BS_CELL: step_code = tm[5:4];
			bs_pkg::BS_OPEN: step_code = tm[3:2];
			bs_pkg::BS_LOAD: step_code = tm[1:0];
			bs_pkg::BS_REC:  step_code = skip2 ? 2'b00 : tm[1:0];
			default:         step_code = 2'b00;
		endcase
	endfunction

	// ======================================================================
	// Registers
	logic [5:0]        timing_reg;
	logic              skip2_reg;
	logic [2:0]        cur_reg;
	logic              aborted_n_reg;
	logic [7:0]        cell_res_reg;
	logic [7:0]        open_res_reg;
	logic [7:0]        load_res_reg;
	logic [4:0]        sense_reg;
	logic [7:0]        dsc_reg;
	logic              keepalive_reg;
	logic              ldo_sel_reg;
	bs_pkg::bs_strap_s strap_reg;
	logic              strap_taken_reg;
	bs_pkg::bs_meas_e  st_reg;
	bs_pkg::bs_meas_e  st_next;
	logic [9:0]        wait_reg;
	logic [PW-1:0]     pre_reg;
	logic [PW-1:0]     tick_cnt_reg;
	logic [8:0]        boot_ms_reg;
	logic [12:0]       ka_ms_reg;
	logic              shutdown_reg;

	logic       wr_imp;
	logic       start_wr;
	logic       abort_wr;
	logic       active;
	logic       step_done;
	logic [1:0] cur_code;
	logic       sample_now;
	logic       cfg_clr;
	logic       ms_tick;
	logic [8:0] boot_target;

	assign wr_imp     = i_bus.wr && i_bus.addr == `BS_OFF_IMP_CTRL;
	assign active     = st_reg != bs_pkg::BS_IDLE;
	assign start_wr   = wr_imp && i_bus.wdata[`BS_IMP_START_BIT] && !active;
	assign abort_wr   = wr_imp && i_bus.wdata[`BS_IMP_ABORT_BIT] && active;
	assign step_done  = wait_reg == 10'd0;
	assign cur_code   = step_code(st_reg, timing_reg, skip2_reg);
	assign sample_now = step_done && cur_code != 2'b00 && st_reg != bs_pkg::BS_REC && active;
	assign cfg_clr    = i_soft_rst && strap_reg.boot_cfg[`BS_BOOT_SRD_BIT];
	assign ms_tick    = tick_cnt_reg == PW'(CYC_PER_MS - 1);

	// ======================================================================
	// Software-written configuration
	always_ff @(posedge i_ref_clk)
	begin
		if (!i_rstn || cfg_clr)
		begin
			timing_reg  <= `BS_RST_TIMING;
			{skip2_reg, cur_reg} <= `BS_RST_IMP;
			sense_reg   <= `BS_RST_SENSE;
			dsc_reg     <= `BS_RST_DSC;
			ldo_sel_reg <= `BS_RST_LDO_SEL;
		end
		else if (i_bus.wr)
		begin
			case (i_bus.addr)
				`BS_OFF_TIMING:   timing_reg <= i_bus.wdata[5:0];
				`BS_OFF_IMP_CTRL: {skip2_reg, cur_reg} <= i_bus.wdata[3:0];
				`BS_OFF_SENSE:    sense_reg <= {i_bus.wdata[7], i_bus.wdata[3:0]};
				`BS_OFF_DSC:      dsc_reg <= i_bus.wdata & `BS_DSC_WR_MASK;
				`BS_OFF_UVLO:     ldo_sel_reg <= i_bus.wdata[0];
				default:          ldo_sel_reg <= ldo_sel_reg;
			endcase
		end
	end

	// Straps are caught by the first clock after reset release.
	always_ff @(posedge i_ref_clk)
	begin
		if (!i_rstn)
		begin
			strap_reg       <= '0;
			strap_taken_reg <= 1'b0;
		end
		else if (!strap_taken_reg)
		begin
			strap_reg       <= i_strap;
			strap_taken_reg <= 1'b1;
		end
	end

	// ======================================================================
	// Impedance sequencer
	always_comb
	begin
		st_next = st_reg;
		case (st_reg)
			bs_pkg::BS_IDLE: if (start_wr) st_next = bs_pkg::BS_CELL;
			bs_pkg::BS_CELL: if (step_done) st_next = bs_pkg::BS_OPEN;
			bs_pkg::BS_OPEN: if (step_done) st_next = bs_pkg::BS_LOAD;
			bs_pkg::BS_LOAD: if (step_done) st_next = bs_pkg::BS_REC;
			bs_pkg::BS_REC:  if (step_done) st_next = bs_pkg::BS_IDLE;
			default:         st_next = bs_pkg::BS_IDLE;
		endcase
		if (abort_wr)
			st_next = bs_pkg::BS_IDLE;
	end

	always_ff @(posedge i_ref_clk)
	begin
		if (!i_rstn)
			st_reg <= bs_pkg::BS_IDLE;
		else
			st_reg <= st_next;
	end

	// Each step reloads its own wait and restarts the millisecond prescaler.
	always_ff @(posedge i_ref_clk)
	begin
		if (!i_rstn)
		begin
			wait_reg <= 10'd0;
			pre_reg  <= '0;
		end
		else if (st_reg != st_next)
		begin
			wait_reg <= delay_ms(step_code(st_next, timing_reg, skip2_reg));
			pre_reg  <= '0;
		end
		else if (!step_done)
		begin
			if (pre_reg == PW'(CYC_PER_MS - 1))
			begin
				pre_reg  <= '0;
				wait_reg <= wait_reg - 10'd1;
			end
			else
				pre_reg <= pre_reg + PW'(1);
		end
	end

	// ======================================================================
	// Results
	always_ff @(posedge i_ref_clk)
	begin
		if (!i_rstn)
		begin
			cell_res_reg  <= `BS_RES_SKIP;
			open_res_reg  <= `BS_RES_SKIP;
			load_res_reg  <= `BS_RES_SKIP;
			aborted_n_reg <= 1'b1;
		end
		else if (abort_wr)
		begin
			cell_res_reg  <= `BS_RES_FAIL;
			open_res_reg  <= `BS_RES_FAIL;
			load_res_reg  <= `BS_RES_FAIL;
			aborted_n_reg <= 1'b0;
		end
		else if (start_wr)
		begin
			aborted_n_reg <= 1'b1;
			if (timing_reg[5:4] == 2'b00) cell_res_reg <= `BS_RES_SKIP;
			if (timing_reg[3:2] == 2'b00) open_res_reg <= `BS_RES_SKIP;
			if (timing_reg[1:0] == 2'b00) load_res_reg <= `BS_RES_SKIP;
		end
		else if (sample_now)
		begin
			case (st_reg)
				bs_pkg::BS_CELL: cell_res_reg <= i_adc_error ? `BS_RES_FAIL : i_adc_code;
				bs_pkg::BS_OPEN: open_res_reg <= i_adc_error ? `BS_RES_FAIL : i_adc_code;
				default:         load_res_reg <= i_adc_error ? `BS_RES_FAIL : i_adc_code;
			endcase
		end
	end

	assign o_adc_sample   = sample_now;
	// A skipped open-cell step must not open the switch, not even for its one pass-through cycle.
	assign o_switch_open  = (st_reg == bs_pkg::BS_OPEN || st_reg == bs_pkg::BS_LOAD
		|| st_reg == bs_pkg::BS_REC) && timing_reg[3:2] != 2'b00;
	assign o_test_current = (st_reg == bs_pkg::BS_LOAD && cur_reg != 3'b111) ? cur_reg : 3'b000;

	// ======================================================================
	// Boot delay, power-up and processor keepalive
	always_ff @(posedge i_ref_clk)
	begin
		if (!i_rstn)
			tick_cnt_reg <= '0;
		else if (ms_tick)
			tick_cnt_reg <= '0;
		else
			tick_cnt_reg <= tick_cnt_reg + PW'(1);
	end

	always_comb
	begin
		case (strap_reg.boot_cfg[1:0])
			2'b00:   boot_target = `BS_BOOT0_MS;
			2'b01:   boot_target = `BS_BOOT1_MS;
			2'b10:   boot_target = `BS_BOOT2_MS;
			default: boot_target = `BS_BOOT3_MS;
		endcase
	end

	always_ff @(posedge i_ref_clk)
	begin
		if (!i_rstn)
			boot_ms_reg <= 9'd0;
		else if (strap_taken_reg && ms_tick && boot_ms_reg != boot_target)
			boot_ms_reg <= boot_ms_reg + 9'd1;
	end

	assign o_boot_done    = strap_taken_reg && boot_ms_reg == boot_target;
	assign o_power_seq_go = o_boot_done && !strap_reg.start_off && !shutdown_reg;

	always_ff @(posedge i_ref_clk)
	begin
		if (!i_rstn)
			keepalive_reg <= 1'b0;
		else if (!strap_taken_reg)
			keepalive_reg <= i_strap.keepalive;
		else if (i_bus.wr && i_bus.addr == `BS_OFF_HSHK && i_bus.wdata[0] && !shutdown_reg)
			keepalive_reg <= 1'b1;
	end

	always_ff @(posedge i_ref_clk)
	begin
		if (!i_rstn)
		begin
			ka_ms_reg    <= 13'd0;
			shutdown_reg <= 1'b0;
		end
		else if (ka_ms_reg == `BS_KEEPALIVE_MS)
			shutdown_reg <= !keepalive_reg || shutdown_reg;
		else if (ms_tick && !keepalive_reg)
			ka_ms_reg <= ka_ms_reg + 13'd1;
	end

	assign o_shutdown = shutdown_reg;

	// ======================================================================
	// Sense mux, pulls, discharge and lockout selects
	assign o_sense_enable     = sense_reg[4];
	assign o_sense_select     = sense_reg[2:0];
	assign o_sense_pulldown   = !sense_reg[4] && !sense_reg[3];
	assign o_key_pull_en      = strap_reg.boot_cfg[`BS_BOOT_PULL_BIT];
	assign o_discharge[3]     = i_enter_off || (dsc_reg[`BS_DSC_BST_PAS] && i_boost_enable_field == 2'b00);
	assign o_discharge[2]     = i_enter_off || (dsc_reg[`BS_DSC_BST_ACT] && i_boost_enable_field == 2'b00);
	assign o_discharge[1]     = i_enter_off || (dsc_reg[`BS_DSC_BCK_PAS] && i_buck_enable_field == 2'b00);
	assign o_discharge[0]     = i_enter_off || (dsc_reg[`BS_DSC_BCK_ACT] && i_buck_enable_field == 2'b00);
	assign o_passive_loads_en = i_off_mode && strap_reg.glb_pas;
	assign o_ldo_lockout_sel  = ldo_sel_reg;
	assign o_conv_lockout_sel = strap_reg.conv_lockout;

	// ======================================================================
	// Register read port
	always_ff @(posedge i_ref_clk)
	begin
		if (!i_rstn)
			o_reg_rdata <= 8'h00;
		else if (i_bus.rd)
		begin
			case (i_bus.addr)
				`BS_OFF_TIMING:   o_reg_rdata <= {2'b00, timing_reg};
				`BS_OFF_IMP_CTRL: o_reg_rdata <= {active, aborted_n_reg, 2'b00, skip2_reg, cur_reg};
				`BS_OFF_CELL_RES: o_reg_rdata <= cell_res_reg;
				`BS_OFF_OPEN_RES: o_reg_rdata <= open_res_reg;
				`BS_OFF_LOAD_RES: o_reg_rdata <= load_res_reg;
				`BS_OFF_SENSE:    o_reg_rdata <= {sense_reg[4], 3'b000, sense_reg[3:0]};
				`BS_OFF_BOOT:     o_reg_rdata <= strap_reg.boot_cfg;
				`BS_OFF_PINS:     o_reg_rdata <= {4'h0, i_pins};
				`BS_OFF_DSC:      o_reg_rdata <= dsc_reg;
				`BS_OFF_HSHK:     o_reg_rdata <= {strap_reg.start_off, strap_reg.glb_pas, 5'h00, keepalive_reg};
				`BS_OFF_UVLO:     o_reg_rdata <= {6'h00, strap_reg.conv_lockout, ldo_sel_reg};
				default:          o_reg_rdata <= 8'h00;
			endcase
		end
	end

	assign o_addr_valid = (i_bus.addr >= `BS_OFF_TIMING && i_bus.addr <= `BS_OFF_LOAD_RES)
		|| (i_bus.addr >= `BS_OFF_SENSE && i_bus.addr <= `BS_OFF_UVLO);

	// ======================================================================
	// Checks
	default clocking cb @(posedge i_ref_clk); endclocking
	default disable iff (!i_rstn);

	AST_START_TAKES: assert property (start_wr && !i_bus.wdata[`BS_IMP_ABORT_BIT] |=> active && aborted_n_reg)
		else $error("start write did not begin a measurement");
	AST_BUSY_IGNORED: assert property (active && wr_imp && !abort_wr && !step_done |=> st_reg == $past(st_reg))
		else $error("start write disturbed a running measurement");
	AST_ACTIVE_READ: assert property (i_bus.rd && i_bus.addr == `BS_OFF_IMP_CTRL |=> o_reg_rdata[7] == $past(active))
		else $error("active bit readback wrong");
	AST_ABORT: assert property (abort_wr |=> !active && !aborted_n_reg && cell_res_reg == `BS_RES_FAIL)
		else $error("abort not honoured");
	AST_CURRENT: assert property (o_test_current != 3'b000 |-> st_reg == bs_pkg::BS_LOAD)
		else $error("test current outside loaded step");
	AST_SKIP_ZERO: assert property (start_wr |=> (timing_reg[5:4] != 2'b00 || cell_res_reg == `BS_RES_SKIP)
		&& (timing_reg[3:2] != 2'b00 || open_res_reg == `BS_RES_SKIP)
		&& (timing_reg[1:0] != 2'b00 || load_res_reg == `BS_RES_SKIP))
		else $error("skipped result not zero");
	AST_SWITCH: assert property ((st_reg == bs_pkg::BS_OPEN || st_reg == bs_pkg::BS_LOAD)
		&& timing_reg[3:2] == 2'b00 |-> !o_switch_open)
		else $error("switch opened with open-cell skipped");
	AST_SENSE_OFF: assert property (!o_sense_enable |-> o_sense_pulldown == !sense_reg[3])
		else $error("sense off state wrong");
	AST_KEEP: assert property (keepalive_reg && strap_taken_reg |=> keepalive_reg [*3])
		else $error("keepalive cleared after set");
	AST_SHUTDOWN: assert property (ka_ms_reg == `BS_KEEPALIVE_MS && !keepalive_reg |=> o_shutdown)
		else $error("no shutdown after keepalive timeout");
	AST_DSC_OFF: assert property (i_enter_off |-> o_discharge == 4'hf)
		else $error("discharge missing on entering off");
endmodule // bs_config_regs

// ===== hw/bs_consts.svh
// Register offsets, field positions, reset values and timing figures of the battery sense register bank.
`ifndef BS_CONSTS_SVH
`define BS_CONSTS_SVH
// ==========================================================================
// Register offsets
`define BS_OFF_TIMING    8'h0d
`define BS_OFF_IMP_CTRL  8'h0e
`define BS_OFF_CELL_RES  8'h0f
`define BS_OFF_OPEN_RES  8'h10
`define BS_OFF_LOAD_RES  8'h11
`define BS_OFF_SENSE     8'h19
`define BS_OFF_BOOT      8'h1a
`define BS_OFF_PINS      8'h1b
`define BS_OFF_DSC       8'h1c
`define BS_OFF_HSHK      8'h1d
`define BS_OFF_UVLO      8'h1e
// ==========================================================================
// Field positions
`define BS_IMP_START_BIT 7
`define BS_IMP_ABORT_BIT 6
`define BS_IMP_SKIP2_BIT 3
`define BS_SENSE_EN_BIT  7
`define BS_SENSE_FLT_BIT 3
`define BS_BOOT_SRD_BIT  3
`define BS_BOOT_PULL_BIT 2
`define BS_DSC_BST_PAS   6
`define BS_DSC_BST_ACT   5
`define BS_DSC_BCK_PAS   2
`define BS_DSC_BCK_ACT   1
`define BS_DSC_WR_MASK   8'he7
// ==========================================================================
// Reset values and result codes
`define BS_RST_TIMING    6'h00
`define BS_RST_IMP       4'h0
`define BS_RST_SENSE     5'h00
`define BS_RST_DSC       8'h00
`define BS_RST_LDO_SEL   1'b0
`define BS_RES_FAIL      8'hff
`define BS_RES_SKIP      8'h00
// ==========================================================================
// Timing figures
`define BS_CLK_PERIOD_NS 50
`define BS_MS_NS         1000000
`define BS_CYC_PER_MS    (`BS_MS_NS / `BS_CLK_PERIOD_NS)
`define BS_T_SHORT_MS    10'd10
`define BS_T_MID_MS      10'd100
`define BS_T_LONG_MS     10'd1000
`define BS_BOOT0_MS      9'd80
`define BS_BOOT1_MS      9'd120
`define BS_BOOT2_MS      9'd220
`define BS_BOOT3_MS      9'd420
`define BS_KEEPALIVE_MS  13'd5000
`endif

// ===== hw/bs_pkg.sv
// Types shared by the battery sense register bank.
package bs_pkg;
	typedef enum logic [4:0] {
		BS_IDLE = 5'b00001,
		BS_CELL = 5'b00010,
		BS_OPEN = 5'b00100,
		BS_LOAD = 5'b01000,
		BS_REC  = 5'b10000
	} bs_meas_e;

	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
	} bs_bus_s;

	typedef struct packed {
		logic [7:0] boot_cfg;
		logic       start_off;
		logic       glb_pas;
		logic       keepalive;
		logic       conv_lockout;
	} bs_strap_s;
endpackage

// ===== tb/bs_adc_model.sv
// Behavioural converter front-end that answers the sample strobes of the battery sense block.
`timescale 1ns/100ps

module bs_adc_model (
	input  wire logic       i_clk,
	input  wire logic       i_sample,
	input  wire logic       i_err_req,
	output logic [7:0]      o_code,
	output logic            o_error
);
	logic [7:0] code_reg = 8'h31;

	// Every sample gets a fresh code; between samples the lines show the inverse so stale data never matches.
	always_ff @(posedge i_clk)
	begin
		if (i_sample)
			code_reg <= code_reg + 8'h01;
	end
	assign o_code  = i_sample ? code_reg : ~code_reg;
	assign o_error = i_sample & i_err_req;
endmodule // bs_adc_model

// ===== tb/pmic_battery_sense_config_regs_tb.sv
// Self-checking testbench for the battery sense register bank.
`timescale 1ns/100ps

module pmic_battery_sense_config_regs_tb;
	logic               clk, rstn, soft_rst, enter_off, off_mode, err_req;
	bs_pkg::bs_bus_s    bus;
	bs_pkg::bs_strap_s  strap;
	logic [3:0]         pins, dsc;
	logic [1:0]         bst_en, bck_en;
	logic [7:0]         rdata, adc_code, sc;
	logic [2:0]         test_cur, sense_sel;
	logic               addr_valid, adc_sample, adc_error, sw_open, sense_en, sense_pd;
	logic               key_pull, boot_done, seq_go, pas_en, shutdown, ldo_sel, conv_sel;
	int                 err_count, num_checks, cyc;

	bs_config_regs #(.CYC_PER_MS(10)) i_bs_config_regs (
		.i_ref_clk(clk), .i_rstn(rstn), .i_bus(bus), .o_reg_rdata(rdata), .o_addr_valid(addr_valid),
		.i_strap(strap), .i_soft_rst(soft_rst), .i_pins(pins), .i_adc_code(adc_code),
		.i_adc_error(adc_error), .o_adc_sample(adc_sample), .o_switch_open(sw_open),
		.o_test_current(test_cur), .o_sense_enable(sense_en), .o_sense_select(sense_sel),
		.o_sense_pulldown(sense_pd), .o_key_pull_en(key_pull), .o_boot_done(boot_done),
		.o_power_seq_go(seq_go), .i_boost_enable_field(bst_en), .i_buck_enable_field(bck_en),
		.i_enter_off(enter_off), .i_off_mode(off_mode), .o_discharge(dsc),
		.o_passive_loads_en(pas_en), .o_shutdown(shutdown), .o_ldo_lockout_sel(ldo_sel),
		.o_conv_lockout_sel(conv_sel));

	bs_adc_model i_bs_adc_model (.i_clk(clk), .i_sample(adc_sample), .i_err_req(err_req),
		.o_code(adc_code), .o_error(adc_error));

	// ==========================================================================
	// Clock, cycle count since reset release
	initial
	begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	always @(posedge clk) cyc <= rstn ? cyc + 1 : 0;

	// ==========================================================================
	// Shared tasks
	task automatic end_sim();
		$display("Checks %0d, mismatches %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		num_checks++;
		if (seen !== exp)
		begin
			err_count++;
			$display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic chk_rng(input int n, input int lo, input int hi);
		chk(16'(n >= lo && n <= hi), 16'h1);
	endtask
	task automatic fail_wait();
		err_count++;
		$display("MISMATCH t=%0t wait ran out", $time);
		end_sim();
	endtask
	task automatic step(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		bus.addr = a;
		bus.wdata = d;
		bus.wr = 1'b1;
		step(1);
		bus.wr = 1'b0;
		step(1);
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic v);
		bus.addr = a;
		bus.rd = 1'b1;
		step(1);
		v = addr_valid;
		bus.rd = 1'b0;
		step(1);
		d = rdata;
	endtask
	task automatic rchk(input logic [7:0] a, input logic [7:0] e);
		logic [7:0] d;
		logic v;
		rd(a, d, v);
		chk({v, d}, {1'b1, e});
	endtask
	task automatic wait_sample(output int n);
		n = 0;
		do
		begin
			step(1);
			n++;
			if (n > 12000)
				fail_wait();
		end
		while (adc_sample !== 1'b1);
		sc = sc + 8'h01;
	endtask
	task automatic wait_idle(output int p, output logic [7:0] d);
		logic v;
		p = 0;
		do
		begin
			rd(8'h0e, d, v);
			p++;
			if (p > 1000)
				fail_wait();
		end
		while (d[7] !== 1'b0);
	endtask

	// ==========================================================================
	// Scenarios
	task automatic t_boot();
		while (boot_done !== 1'b1)
		begin
			step(1);
			if (cyc > 2000)
				fail_wait();
		end
		chk_rng(cyc, 795, 805);
		chk(seq_go, 1'b1);
		chk(key_pull, 1'b1);
		$display("t_boot done");
	endtask
	task automatic t_regs();
		logic [7:0] d;
		logic v;
		rchk(8'h0d, 8'h00);
		wr(8'h0d, 8'hff);
		rchk(8'h0d, 8'h3f);
		wr(8'h1a, 8'h00);
		rchk(8'h1a, 8'h0c);
		pins = 4'ha;
		rchk(8'h1b, 8'h0a);
		pins = 4'h5;
		rchk(8'h1b, 8'h05);
		rchk(8'h1d, 8'h40);
		wr(8'h1e, 8'h01);
		rchk(8'h1e, 8'h03);
		chk({ldo_sel, conv_sel}, 2'b11);
		wr(8'h1e, 8'h00);
		chk({ldo_sel, conv_sel}, 2'b01);
		rd(8'h20, d, v);
		chk({v, d}, 9'h000);
		$display("t_regs done");
	endtask
	task automatic t_sense();
		for (int i = 0; i < 8; i++)
		begin
			wr(8'h19, 8'h80 | 8'(i));
			chk({sense_en, sense_pd, sense_sel}, {2'b10, 3'(i)});
		end
		wr(8'h19, 8'h00);
		chk({sense_en, sense_pd}, 2'b01);
		wr(8'h19, 8'h08);
		chk({sense_en, sense_pd}, 2'b00);
		rchk(8'h19, 8'h08);
		$display("t_sense done");
	endtask
	task automatic t_dsc();
		wr(8'h1c, 8'h66);
		rchk(8'h1c, 8'h66);
		bst_en = 2'b00;
		step(1);
		chk(dsc, 4'hc);
		bck_en = 2'b00;
		step(1);
		chk(dsc, 4'hf);
		wr(8'h1c, 8'h00);
		chk(dsc, 4'h0);
		enter_off = 1'b1;
		off_mode = 1'b1;
		step(1);
		chk({dsc, pas_en}, 5'h1f);
		enter_off = 1'b0;
		off_mode = 1'b0;
		bst_en = 2'b01;
		bck_en = 2'b01;
		step(1);
		chk({dsc, pas_en}, 5'h00);
		$display("t_dsc done");
	endtask
	task automatic t_meas();
		int n;
		logic [7:0] b, d;
		b = sc;
		wr(8'h0d, 8'h15);
		wr(8'h0e, 8'h83);
		step(40);
		wr(8'h0e, 8'h83);
		rchk(8'h0e, 8'hc3);
		wait_sample(n);
		chk_rng(n, 53, 59);
		chk({sw_open, test_cur}, 4'h0);
		wait_sample(n);
		chk_rng(n, 99, 103);
		chk({sw_open, test_cur}, 4'h8);
		wait_sample(n);
		chk_rng(n, 99, 103);
		chk({sw_open, test_cur}, 4'hb);
		step(5);
		chk(sw_open, 1'b1);
		wait_idle(n, d);
		chk_rng(n, 46, 53);
		rchk(8'h0f, b);
		rchk(8'h10, b + 8'h01);
		rchk(8'h11, b + 8'h02);
		$display("t_meas done");
	endtask
	task automatic t_abort();
		int n;
		wr(8'h0e, 8'h80);
		step(30);
		wr(8'h0e, 8'h40);
		rchk(8'h0e, 8'h00);
		for (int a = 8'h0f; a <= 8'h11; a++)
			rchk(8'(a), 8'hff);
		n = 0;
		repeat (150)
		begin
			step(1);
			n += int'(adc_sample === 1'b1);
		end
		chk(16'(n), 16'h0);
		$display("t_abort done");
	endtask
	task automatic t_skip();
		int n;
		logic [7:0] b, d;
		b = sc;
		wr(8'h0d, 8'h23);
		wr(8'h0e, 8'h8e);
		wait_sample(n);
		chk_rng(n, 997, 1003);
		chk(sw_open, 1'b0);
		step(1);
		chk(sw_open, 1'b0);
		err_req = 1'b1;
		wait_sample(n);
		chk_rng(n, 9997, 10003);
		chk({sw_open, test_cur}, 4'h6);
		step(1);
		err_req = 1'b0;
		wait_idle(n, d);
		chk_rng(n, 1, 3);
		chk(d, 8'h4e);
		rchk(8'h0f, b);
		rchk(8'h10, 8'h00);
		rchk(8'h11, 8'hff);
		$display("t_skip done");
	endtask
	task automatic t_soft();
		wr(8'h0d, 8'h2a);
		wr(8'h1e, 8'h01);
		soft_rst = 1'b1;
		step(1);
		soft_rst = 1'b0;
		step(1);
		rchk(8'h0d, 8'h00);
		rchk(8'h1e, 8'h02);
		$display("t_soft done");
	endtask
	task automatic t_down();
		while (shutdown !== 1'b1)
		begin
			step(1);
			if (cyc > 60000)
				fail_wait();
		end
		chk_rng(cyc, 49995, 50005);
		chk(seq_go, 1'b0);
		wr(8'h1d, 8'h01);
		rchk(8'h1d, 8'h40);
		$display("t_down done");
	endtask
	task automatic t_rst();
		rstn = 1'b0;
		step(2);
		rstn = 1'b1;
		step(2);
		chk(shutdown, 1'b0);
		rchk(8'h0e, 8'h40);
		wr(8'h1d, 8'h01);
		rchk(8'h1d, 8'h41);
		wr(8'h1d, 8'h00);
		rchk(8'h1d, 8'h41);
		$display("t_rst done");
	endtask

	// ==========================================================================
	// Main sequence
	initial
	begin
		rstn = 1'b0;
		bus = '0;
		strap = '{boot_cfg: 8'h0c, start_off: 1'b0, glb_pas: 1'b1, keepalive: 1'b0, conv_lockout: 1'b1};
		{soft_rst, enter_off, off_mode, err_req} = 4'h0;
		pins = 4'h0;
		bst_en = 2'b01;
		bck_en = 2'b01;
		sc = 8'h31;
		err_count = 0;
		num_checks = 0;
		step(16);
		rstn = 1'b1;
		step(2);
		t_boot();
		t_regs();
		t_sense();
		t_dsc();
		t_meas();
		t_abort();
		t_skip();
		t_soft();
		t_down();
		t_rst();
		end_sim();
	end
endmodule // pmic_battery_sense_config_regs_tb
